//--- led_xover_consts.vh
// Register map, field layout, reset values and timing constants of the indicator and pair block
`ifndef LED_XOVER_CONSTS_VH
`define LED_XOVER_CONSTS_VH

// ********************************************************
// Register addresses and data width
// ********************************************************
`define ADDR_W            5
`define DATA_W            16
`define IND_CFG_ADDR      5'h17
`define PAIR_CTL_ADDR     5'h18

// ********************************************************
// Field positions
// ********************************************************
`define SEL_W             4
`define IND_A_LSB         0
`define IND_B_LSB         4
`define PD_ASSIST_BIT     7
`define AUTOSW_BIT        6
`define XOVER_BIT         5
`define DONE_BIT          4
`define SEED_LSB          0
`define SEED_W            4

// ********************************************************
// Reset values and seeds
// ********************************************************
`define IND_A_RST         4'h0
`define IND_B_RST         4'h1
`define PD_ASSIST_RST     1'b1
`define AUTOSW_RST        1'b1
`define XOVER_RST         1'b0
`define SEED_RST          4'h0
`define SEED_ZERO         4'h0
`define SEED_INTERNAL     4'h5

// ********************************************************
// Indicator source codes
// ********************************************************
`define SEL_LINK          4'h0
`define SEL_ANY_ACT       4'h1
`define SEL_TX_ACT        4'h2
`define SEL_RX_ACT        4'h3
`define SEL_COLLISION     4'h4
`define SEL_SPEED_100     4'h5
`define SEL_SPEED_10      4'h6
`define SEL_FULL_DUPLEX   4'h7
`define SEL_LINK_BLINK    4'h8

// ********************************************************
// Timing
// ********************************************************
`define CLK_MHZ           50
`define RST_MIN_CYCLES    30
`define ATTEMPT_US        50
`define ATTEMPT_CYCLES    (`ATTEMPT_US * `CLK_MHZ)
`define BLINK_HALF_MS     40
`define BLINK_HALF_CYCLES (`BLINK_HALF_MS * 1000 * `CLK_MHZ)
`define STRETCH_TICKS     2'h2

`endif

//--- blink_timer.v
// Divider giving the blink half-period tick and the blink phase
`timescale 1ns/1ps
`include "led_xover_consts.vh"

module blink_timer #(
  parameter integer HALF_CYCLES = `BLINK_HALF_CYCLES
) (
  input  wire mclk,
  input  wire rst,
  output reg  tick,
  output reg  phase
);

  reg [31:0] cnt_reg;

  // ********************************************************
  // Divider
  // ********************************************************
  always @(posedge mclk) begin
    if (rst) begin
      cnt_reg <= 32'h0;
      tick    <= 1'b0;
      phase   <= 1'b0;
    end else if (cnt_reg == HALF_CYCLES - 1) begin
      cnt_reg <= 32'h0;
      tick    <= 1'b1;
      phase   <= ~phase;
    end else begin
      cnt_reg <= cnt_reg + 32'h1;
      tick    <= 1'b0;
    end
  end

endmodule // blink_timer

//--- pair_switch_seq.v
// Straight/crossover attempt sequencer steered by the seed bits
`timescale 1ns/1ps
`include "led_xover_consts.vh"

module pair_switch_seq #(
  parameter integer ATTEMPT = `ATTEMPT_CYCLES
) (
  input  wire       mclk,
  input  wire       rst,
  input  wire       run,
  input  wire       restart,
  input  wire [3:0] seed,
  input  wire       link_good,
  output reg        crossover,
  output reg        done
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_TRY  = 2'h1;
  localparam [1:0] ST_DONE = 2'h2;

  reg [1:0]  state_reg;
  reg [1:0]  attempt_reg;
  reg [31:0] timer_reg;

  // ********************************************************
  // Sequencer
  // ********************************************************
  always @(posedge mclk) begin
    if (rst) begin
      state_reg   <= ST_IDLE;
      attempt_reg <= 2'h0;
      timer_reg   <= 32'h0;
      crossover   <= `XOVER_RST;
      done        <= 1'b0;
    end else if (restart || !run) begin
      state_reg <= ST_IDLE;
      done      <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          attempt_reg <= 2'h0;
          timer_reg   <= 32'h0;
          crossover   <= seed[0];
          state_reg   <= ST_TRY;
        end
        ST_TRY: begin
          if (link_good) begin
            state_reg <= ST_DONE;
            done      <= 1'b1;
          end else if (timer_reg == ATTEMPT - 1) begin
            // Each new attempt takes the next seed bit, wrapping after four
            timer_reg   <= 32'h0;
            attempt_reg <= attempt_reg + 2'h1;
            crossover   <= seed[attempt_reg + 2'h1];
          end else begin
            timer_reg <= timer_reg + 32'h1;
          end
        end
        ST_DONE: begin
          if (!link_good) begin
            state_reg <= ST_IDLE;
            done      <= 1'b0;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          done      <= 1'b0;
        end
      endcase
    end
  end

endmodule // pair_switch_seq

//--- led_select_and_crossover_ctrl.v
// Indicator source selection and straight/crossover control registers
//
// Functional notes
// - Four-bit source selector per indicator, codes 0-8, higher codes dark
// - Codes 5-7 show 100M, 10M, full duplex
// - Code 8: on with link, blink on activity
// - Reset: second selector 1, first selector 0
// - Parallel-detect assist bit 7, resets to one
// - Autoswitch enable bit 6, resets to one
// - Bit 5 reports crossover, resets straight
// - Bit 5 read-only while autoswitch enabled
// - Bit 5 forces assignment while autoswitch disabled
// - Bit 4 reads sequence completed, else zero
// - Seed bits 3:0 steer attempts, reset zero
// - Zero seed replaced by internal seed 0101
`timescale 1ns/1ps
`include "led_xover_consts.vh"

module led_select_and_crossover_ctrl #(
  parameter integer BLINK_HALF_CYCLES = `BLINK_HALF_CYCLES,
  parameter integer ATTEMPT_CYCLES    = `ATTEMPT_CYCLES
) (
  input  wire                 mclk,
  input  wire                 rst,
  input  wire [`ADDR_W-1:0]   reg_addr,
  input  wire [`DATA_W-1:0]   reg_wdata,
  input  wire                 reg_wr,
  input  wire                 reg_rd,
  output reg  [`DATA_W-1:0]   reg_rdata,
  input  wire                 link_good,
  input  wire                 tx_activity,
  input  wire                 rx_activity,
  input  wire                 collision,
  input  wire                 speed_100,
  input  wire                 speed_10,
  input  wire                 full_duplex,
  input  wire                 local_aneg_en,
  input  wire                 partner_aneg_seen,
  output reg                  indicator_a,
  output reg                  indicator_b,
  output reg                  pair_crossover,
  output reg                  pair_switch_active
);

  // ********************************************************
  // Functions
  // ********************************************************

  // Source multiplexer shared by both indicators
  function ind_level;
    input [`SEL_W-1:0] sel;
    input              link;
    input              any_act;
    input              tx_act;
    input              rx_act;
    input              col;
    input              s100;
    input              s10;
    input              fdx;
    input              blink;
    begin
      case (sel)
        `SEL_LINK:        ind_level = link;
        `SEL_ANY_ACT:     ind_level = any_act;
        `SEL_TX_ACT:      ind_level = tx_act;
        `SEL_RX_ACT:      ind_level = rx_act;
        `SEL_COLLISION:   ind_level = col;
        `SEL_SPEED_100:   ind_level = s100;
        `SEL_SPEED_10:    ind_level = s10;
        `SEL_FULL_DUPLEX: ind_level = fdx;
        `SEL_LINK_BLINK:  ind_level = blink;
        default:          ind_level = 1'b0;
      endcase
    end
  endfunction

  // Activity stretcher: short events stay visible for a few blink ticks
  function [1:0] stretch_next;
    input [1:0] cnt;
    input       event_in;
    input       tick;
    begin
      if (event_in) begin
        stretch_next = `STRETCH_TICKS;
      end else if (tick && cnt != 2'h0) begin
        stretch_next = cnt - 2'h1;
      end else begin
        stretch_next = cnt;
      end
    end
  endfunction

  // Zero seed falls back to the built-in pattern
  function [`SEED_W-1:0] seed_eff;
    input [`SEED_W-1:0] seed;
    begin
      if (seed == `SEED_ZERO) begin
        seed_eff = `SEED_INTERNAL;
      end else begin
        seed_eff = seed;
      end
    end
  endfunction

  // Register index decode, shared by the write and read paths
  function addr_is;
    input [`ADDR_W-1:0] addr;
    input [`ADDR_W-1:0] target;
    begin
      addr_is = (addr == target);
    end
  endfunction

  // ********************************************************
  // Register state
  // ********************************************************
  reg [`SEL_W-1:0]  ind_a_sel_reg;
  reg [`SEL_W-1:0]  ind_b_sel_reg;
  reg               pd_assist_reg;
  reg               autosw_reg;
  reg               xover_force_reg;
  reg [`SEED_W-1:0] seed_reg;
  reg               restart_reg;

  reg [1:0]         tx_str_reg;
  reg [1:0]         rx_str_reg;
  reg [1:0]         col_str_reg;

  wire              wr_ind;
  wire              wr_pair;
  wire              wr_force;
  wire              blink_tick;
  wire              blink_phase;
  wire              seq_xover;
  wire              seq_done;
  wire              switch_run;
  wire              xover_eff;
  wire              done_eff;
  wire              tx_s;
  wire              rx_s;
  wire              col_s;
  wire              any_s;
  wire              blink_level;
  wire              ind_a_next;
  wire              ind_b_next;

  reg [`DATA_W-1:0] rdata_next;
  reg [`DATA_W-1:0] ind_cfg_word;
  reg [`DATA_W-1:0] pair_ctl_word;
  reg [`SEED_W-1:0] seed_used;

  // ********************************************************
  // Write decode
  // ********************************************************
  assign wr_ind   = reg_wr && addr_is(reg_addr, `IND_CFG_ADDR);
  assign wr_pair  = reg_wr && addr_is(reg_addr, `PAIR_CTL_ADDR);
  // Bit 5 is only taken from a write that also turns autoswitch off
  assign wr_force = wr_pair && !reg_wdata[`AUTOSW_BIT];

  // ********************************************************
  // Register writes
  // ********************************************************
  always @(posedge mclk) begin
    if (rst) begin
      ind_a_sel_reg <= `IND_A_RST;
      ind_b_sel_reg <= `IND_B_RST;
    end else if (wr_ind) begin
      // Upper byte is dropped, software keeps it at zero
      ind_a_sel_reg <= reg_wdata[`IND_A_LSB +: `SEL_W];
      ind_b_sel_reg <= reg_wdata[`IND_B_LSB +: `SEL_W];
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      pd_assist_reg <= `PD_ASSIST_RST;
      autosw_reg    <= `AUTOSW_RST;
      seed_reg      <= `SEED_RST;
    end else if (wr_pair) begin
      pd_assist_reg <= reg_wdata[`PD_ASSIST_BIT];
      autosw_reg    <= reg_wdata[`AUTOSW_BIT];
      seed_reg      <= reg_wdata[`SEED_LSB +: `SEED_W];
    end
  end

  // Forced assignment only taken by a write that leaves autoswitch off
  always @(posedge mclk) begin
    if (rst) begin
      xover_force_reg <= `XOVER_RST;
    end else if (wr_force) begin
      xover_force_reg <= reg_wdata[`XOVER_BIT];
    end
  end

  // Any write to the pair register restarts the attempt sequence
  always @(posedge mclk) begin
    if (rst) begin
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= wr_pair;
    end
  end

  // ********************************************************
  // Pair switching
  // ********************************************************

  // Runs with local negotiation, or with assist when partner negotiates
  assign switch_run = autosw_reg &&
                      (local_aneg_en ||
                       (pd_assist_reg && partner_aneg_seen));

  // Sequencer never sees a zero seed
  always @* begin
    seed_used = seed_eff(seed_reg);
  end

  pair_switch_seq #(
    .ATTEMPT   (ATTEMPT_CYCLES)
  ) u_seq (
    .mclk      (mclk),
    .rst       (rst),
    .run       (switch_run),
    .restart   (restart_reg),
    .seed      (seed_used),
    .link_good (link_good),
    .crossover (seq_xover),
    .done      (seq_done)
  );

  // Sequencer choice is ignored while autoswitch is off
  assign xover_eff = autosw_reg ? seq_xover : xover_force_reg;
  assign done_eff  = autosw_reg && seq_done;

  always @(posedge mclk) begin
    if (rst) begin
      pair_crossover     <= `XOVER_RST;
      pair_switch_active <= 1'b0;
    end else begin
      pair_crossover     <= xover_eff;
      pair_switch_active <= switch_run && !seq_done;
    end
  end

  // ********************************************************
  // Indicators
  // ********************************************************
  blink_timer #(
    .HALF_CYCLES (BLINK_HALF_CYCLES)
  ) u_blink (
    .mclk        (mclk),
    .rst         (rst),
    .tick        (blink_tick),
    .phase       (blink_phase)
  );

  always @(posedge mclk) begin
    if (rst) begin
      tx_str_reg  <= 2'h0;
      rx_str_reg  <= 2'h0;
      col_str_reg <= 2'h0;
    end else begin
      tx_str_reg  <= stretch_next(tx_str_reg, tx_activity, blink_tick);
      rx_str_reg  <= stretch_next(rx_str_reg, rx_activity, blink_tick);
      col_str_reg <= stretch_next(col_str_reg, collision, blink_tick);
    end
  end

  assign tx_s  = (tx_str_reg != 2'h0);
  assign rx_s  = (rx_str_reg != 2'h0);
  assign col_s = (col_str_reg != 2'h0);
  assign any_s = tx_s || rx_s;

  // Lit with link, dark on the off phase while traffic flows
  assign blink_level = link_good && !(any_s && blink_phase);

  assign ind_a_next = ind_level(ind_a_sel_reg, link_good, any_s, tx_s, rx_s,
                                col_s, speed_100, speed_10, full_duplex,
                                blink_level);
  assign ind_b_next = ind_level(ind_b_sel_reg, link_good, any_s, tx_s, rx_s,
                                col_s, speed_100, speed_10, full_duplex,
                                blink_level);

  always @(posedge mclk) begin
    if (rst) begin
      indicator_a <= 1'b0;
      indicator_b <= 1'b0;
    end else begin
      indicator_a <= ind_a_next;
      indicator_b <= ind_b_next;
    end
  end

  // ********************************************************
  // Register images
  // ********************************************************
  // Reserved fields start from zero so they always read back low
  always @* begin
    ind_cfg_word                       = {`DATA_W{1'b0}};
    ind_cfg_word[`IND_A_LSB +: `SEL_W] = ind_a_sel_reg;
    ind_cfg_word[`IND_B_LSB +: `SEL_W] = ind_b_sel_reg;
  end

  // Bits 5 and 4 show live state; bit 5 is the forced value while autoswitch is off
  always @* begin
    pair_ctl_word                       = {`DATA_W{1'b0}};
    pair_ctl_word[`PD_ASSIST_BIT]       = pd_assist_reg;
    pair_ctl_word[`AUTOSW_BIT]          = autosw_reg;
    pair_ctl_word[`XOVER_BIT]           = xover_eff;
    pair_ctl_word[`DONE_BIT]            = done_eff;
    pair_ctl_word[`SEED_LSB +: `SEED_W] = seed_reg;
  end

  // ********************************************************
  // Register reads
  // ********************************************************
  always @* begin
    if (addr_is(reg_addr, `IND_CFG_ADDR)) begin
      rdata_next = ind_cfg_word;
    end else if (addr_is(reg_addr, `PAIR_CTL_ADDR)) begin
      rdata_next = pair_ctl_word;
    end else begin
      rdata_next = {`DATA_W{1'b0}};
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= {`DATA_W{1'b0}};
    end else if (reg_rd) begin
      reg_rdata <= rdata_next;
    end else begin
      reg_rdata <= {`DATA_W{1'b0}};
    end
  end

endmodule // led_select_and_crossover_ctrl

//--- led_xover_checker.sv
// Concurrent checks on the indicator and pair control block ports
`timescale 1ns/1ps
`include "led_xover_consts.vh"
module led_xover_checker (
  input wire        mclk,
  input wire        rst,
  input wire [4:0]  reg_addr,
  input wire [15:0] reg_wdata,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  input wire        link_good,
  input wire        collision,
  input wire        speed_100,
  input wire        speed_10,
  input wire        full_duplex,
  input wire        indicator_a,
  input wire        indicator_b,
  input wire        pair_crossover,
  input wire        pair_switch_active
);
  // ********************************************************
  // Shadow registers
  // ********************************************************
  reg [3:0] sa_reg, sb_reg, seed_reg;
  reg       pd_reg, asw_reg, frc_reg, live_reg;
  wire      wr17 = reg_wr && reg_addr == `IND_CFG_ADDR;
  wire      wr18 = reg_wr && reg_addr == `PAIR_CTL_ADDR;
  wire      rd17 = reg_rd && reg_addr == `IND_CFG_ADDR;
  wire      rd18 = reg_rd && reg_addr == `PAIR_CTL_ADDR;
  wire [3:0] st  = {full_duplex, speed_10, speed_100, collision};
  wire      st_a = st[sa_reg[1:0]];
  always @(posedge mclk) begin
    if (rst) begin
      sa_reg   <= `IND_A_RST;
      sb_reg   <= `IND_B_RST;
      seed_reg <= `SEED_RST;
      pd_reg   <= `PD_ASSIST_RST;
      asw_reg  <= `AUTOSW_RST;
      frc_reg  <= `XOVER_RST;
      live_reg <= 1'h0;
    end else begin
      live_reg <= 1'h1;
      if (wr17) begin
        {sb_reg, sa_reg} <= reg_wdata[7:0];
      end
      if (wr18) begin
        pd_reg   <= reg_wdata[7];
        asw_reg  <= reg_wdata[6];
        seed_reg <= reg_wdata[3:0];
        // Forcing only counts when the same write turns switching off
        if (!reg_wdata[6]) begin
          frc_reg <= reg_wdata[5];
        end
      end
    end
  end
  // ********************************************************
  // Assertions
  // ********************************************************
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence force_wr;
    wr18 && !reg_wdata[`AUTOSW_BIT];
  endsequence
  sequence quiet3;
    (!reg_wr)[*3];
  endsequence
  ind_read_a: assert property (rd17 |=> reg_rdata[7:0] == {sb_reg, sa_reg})
    else $error("indicator config read mismatch");
  upper_zero_a: assert property (reg_rdata[15:8] == 8'h00)
    else $error("upper read bits not zero");
  pair_read_a: assert property (rd18 |=> {reg_rdata[7:6], reg_rdata[3:0]} == {pd_reg, asw_reg, seed_reg})
    else $error("pair control read mismatch");
  done_off_a: assert property (rd18 && !asw_reg |=> !reg_rdata[`DONE_BIT])
    else $error("done bit set while switching disabled");
  link_src_a: assert property (live_reg && sa_reg == 4'h0 |=> indicator_a == $past(link_good))
    else $error("indicator a does not follow link");
  mode_src_a: assert property (live_reg && sa_reg[3:2] == 2'h1 && sa_reg[1:0] != 2'h0
    |=> indicator_a == $past(st_a))
    else $error("indicator a does not follow status");
  col_src_a: assert property (live_reg && sa_reg == 4'h4 && collision ##1 sa_reg == 4'h4
    |=> indicator_a)
    else $error("collision not shown on indicator a");
  blink_dark_a: assert property (live_reg && sa_reg == 4'h8 && !link_good |=> !indicator_a)
    else $error("blink code lit without link");
  undef_dark_a: assert property (live_reg && sb_reg > 4'h8 |=> !indicator_b)
    else $error("undefined code lit indicator b");
  force_hold_a: assert property (force_wr ##1 quiet3 |-> pair_crossover == frc_reg)
    else $error("forced pair setting not applied");
  idle_off_a: assert property ((!asw_reg)[*4] |-> !pair_switch_active)
    else $error("switching runs while disabled");
endmodule // led_xover_checker

bind led_select_and_crossover_ctrl led_xover_checker u_chk (
  .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_good(link_good), .collision(collision),
  .speed_100(speed_100), .speed_10(speed_10), .full_duplex(full_duplex),
  .indicator_a(indicator_a), .indicator_b(indicator_b), .pair_crossover(pair_crossover),
  .pair_switch_active(pair_switch_active));

//--- mgmt_master.sv
// Station management model driving the register port
`timescale 1ns/1ps
module mgmt_master (
  input  wire        mclk,
  output reg  [4:0]  reg_addr,
  output reg  [15:0] reg_wdata,
  output reg         reg_wr,
  output reg         reg_rd,
  input  wire [15:0] reg_rdata
);
  initial begin
    reg_addr  = 5'h00;
    reg_wdata = 16'h0000;
    reg_wr    = 1'h0;
    reg_rd    = 1'h0;
  end
  // Only the low byte is taken, so the upper byte always goes out as zeros
  task wr(input [4:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= {8'h00, d};
      reg_wr    <= 1'h1;
      @(posedge mclk);
      reg_wr    <= 1'h0;
    end
  endtask
  task rd(input [4:0] a, output [15:0] q);
    begin
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'h1;
      @(posedge mclk);
      reg_rd   <= 1'h0;
      #1;
      q = reg_rdata;
    end
  endtask
endmodule // mgmt_master

//--- led_select_and_crossover_ctrl_tb_top.sv
// Self-checking bench for the indicator and pair control block
`timescale 1ns/1ps
`include "led_xover_consts.vh"
module led_select_and_crossover_ctrl_tb_top;
  reg         mclk, rst, link_good, tx_activity, rx_activity, collision;
  reg         speed_100, speed_10, full_duplex, local_aneg_en, partner_aneg_seen;
  wire [4:0]  reg_addr;
  wire [15:0] reg_wdata, reg_rdata;
  wire        reg_wr, reg_rd, indicator_a, indicator_b, pair_crossover, pair_switch_active;
  reg  [11:0] rows [0:15];
  reg  [15:0] q;
  reg         seen_lo, seen_hi;
  integer     err_total, compares, i, n;

  mgmt_master u_mgmt (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  led_select_and_crossover_ctrl #(.BLINK_HALF_CYCLES(8), .ATTEMPT_CYCLES(16)) DUT (
    .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_good(link_good),
    .tx_activity(tx_activity), .rx_activity(rx_activity), .collision(collision),
    .speed_100(speed_100), .speed_10(speed_10), .full_duplex(full_duplex),
    .local_aneg_en(local_aneg_en), .partner_aneg_seen(partner_aneg_seen),
    .indicator_a(indicator_a), .indicator_b(indicator_b),
    .pair_crossover(pair_crossover), .pair_switch_active(pair_switch_active));

  // ********************************************************
  // Compare and report
  // ********************************************************
  task give_verdict;
    begin
      if (err_total == 0 && compares > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk1(input got, input exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("BAD %0t bit got %b want %b", $time, got, exp);
      end
    end
  endtask
  task chk16(input [15:0] got, input [15:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("BAD %0t word got %h want %h", $time, got, exp);
      end
    end
  endtask
  // Bounded wait for the switching sequence to settle
  task wait_idle;
    begin
      n = 0;
      while (pair_switch_active !== 1'h0 && n < 40) begin
        @(posedge mclk);
        #1;
        n = n + 1;
      end
      if (pair_switch_active !== 1'h0) begin
        err_total = err_total + 1;
        $display("BAD %0t switching never settled", $time);
        give_verdict;
      end
    end
  endtask

  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end

  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin
    // Row: code, {link, tx, rx, col, s100, s10, fdx}, expected indicator
    rows[0]  = {4'h0, 7'h40, 1'h1};
    rows[1]  = {4'h0, 7'h00, 1'h0};
    rows[2]  = {4'h4, 7'h08, 1'h1};
    rows[3]  = {4'h4, 7'h47, 1'h0};
    rows[4]  = {4'h5, 7'h04, 1'h1};
    rows[5]  = {4'h5, 7'h03, 1'h0};
    rows[6]  = {4'h6, 7'h02, 1'h1};
    rows[7]  = {4'h7, 7'h01, 1'h1};
    rows[8]  = {4'h7, 7'h4e, 1'h0};
    rows[9]  = {4'h8, 7'h40, 1'h1};
    rows[10] = {4'h8, 7'h00, 1'h0};
    rows[11] = {4'h9, 7'h7f, 1'h0};
    rows[12] = {4'hf, 7'h7f, 1'h0};
    rows[13] = {4'h2, 7'h20, 1'h1};
    rows[14] = {4'h3, 7'h10, 1'h1};
    rows[15] = {4'h1, 7'h20, 1'h1};
    err_total = 0;
    compares = 0;
    rst = 1'h1;
    {link_good, tx_activity, rx_activity, collision, speed_100, speed_10, full_duplex} = 7'h00;
    local_aneg_en = 1'h0;
    partner_aneg_seen = 1'h0;
    repeat (`RST_MIN_CYCLES) @(posedge mclk);
    rst <= 1'h0;
    u_mgmt.rd(`IND_CFG_ADDR, q);
    chk16(q, 16'h0010);
    u_mgmt.rd(`PAIR_CTL_ADDR, q);
    chk16(q & 16'hffcf, 16'h00c0);
    // An unmapped write must leave the indicator config register alone
    u_mgmt.wr(5'h16, 8'hff);
    u_mgmt.rd(5'h16, q);
    chk16(q, 16'h0000);
    u_mgmt.rd(`IND_CFG_ADDR, q);
    chk16(q, 16'h0010);
    for (i = 0; i < 16; i = i + 1) begin
      u_mgmt.wr(`IND_CFG_ADDR, {2{rows[i][11:8]}});
      {link_good, tx_activity, rx_activity, collision, speed_100, speed_10, full_duplex}
        <= rows[i][7:1];
      // Stretched activity needs two blink ticks to die away
      repeat (20) @(posedge mclk);
      #1;
      chk1(indicator_a, rows[i][0]);
      chk1(indicator_b, rows[i][0]);
    end
    // Blink code with steady traffic must show both phases
    u_mgmt.wr(`IND_CFG_ADDR, 8'h88);
    {link_good, tx_activity} <= 2'h3;
    seen_lo = 1'h0;
    seen_hi = 1'h0;
    repeat (24) begin
      @(posedge mclk);
      #1;
      if (indicator_a === 1'h0) seen_lo = 1'h1;
      if (indicator_a === 1'h1) seen_hi = 1'h1;
    end
    chk1(seen_lo, 1'h1);
    chk1(seen_hi, 1'h1);
    {link_good, tx_activity, rx_activity, collision, speed_100, speed_10, full_duplex} <= 7'h00;
    partner_aneg_seen <= 1'h1;
    // Partner negotiating, local negotiation off: assist bit decides
    u_mgmt.wr(`PAIR_CTL_ADDR, 8'h4a);
    repeat (4) @(posedge mclk);
    #1;
    chk1(pair_switch_active, 1'h0);
    u_mgmt.wr(`PAIR_CTL_ADDR, 8'hea);
    repeat (4) @(posedge mclk);
    #1;
    chk1(pair_switch_active, 1'h1);
    chk1(pair_crossover, 1'h0);
    u_mgmt.rd(`PAIR_CTL_ADDR, q);
    chk16(q, 16'h00ca);
    local_aneg_en <= 1'h1;
    u_mgmt.wr(`PAIR_CTL_ADDR, 8'hc0);
    repeat (4) @(posedge mclk);
    #1;
    chk1(pair_crossover, 1'h1);
    link_good <= 1'h1;
    wait_idle;
    repeat (2) @(posedge mclk);
    u_mgmt.rd(`PAIR_CTL_ADDR, q);
    chk16(q, 16'h00f0);
    u_mgmt.wr(`PAIR_CTL_ADDR, 8'h20);
    repeat (4) @(posedge mclk);
    #1;
    chk1(pair_crossover, 1'h1);
    u_mgmt.rd(`PAIR_CTL_ADDR, q);
    chk16(q, 16'h0020);
    u_mgmt.wr(`PAIR_CTL_ADDR, 8'h00);
    repeat (4) @(posedge mclk);
    #1;
    chk1(pair_crossover, 1'h0);
    give_verdict;
  end
endmodule // led_select_and_crossover_ctrl_tb_top
